// ### flash_host_pkg.sv
// constants for the parallel flash program/erase host controller
package flash_host_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  // strobe phase lengths in ns, rounded up to whole cycles
  localparam int SETUP_NS = 50;
  localparam int PULSE_NS = 75;
  localparam int HOLD_NS = 50;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // inter-load limit 30 us; the host must start the next load sooner
  localparam int LOAD_GAP_US = 30;
  localparam int LOAD_GAP_CYC = (LOAD_GAP_US * 1000) / CLK_PERIOD_NS;
  // device closes the load period after 100 us of silence
  localparam int LOAD_CLOSE_US = 100;
  localparam int LOAD_CLOSE_CYC = (LOAD_CLOSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_WORDS = 64;
  localparam int PAGE_LSB = 6;
  localparam int SECTOR_LSB = 16;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h2AAA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hF0;
  // operation_status field positions
  localparam int READY_BIT = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int ERASE_FAIL_BIT = 5;
  localparam int PROGRAM_FAIL_BIT = 4;
  // user commands
  localparam logic [2:0] OP_PROGRAM = 3'h0;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_RESUME = 3'h4;
  localparam logic [2:0] OP_READ_STATUS = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;
  localparam logic [2:0] OP_READ_ARRAY = 3'h7;
endpackage : flash_host_pkg

// ### page_buffer.sv
`timescale 1ns/1ps
// page staging memory: 64 words, registered read data
module page_buffer (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [5:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:63];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : page_buffer

// ### flash_host.sv
`timescale 1ns/1ps
// host controller driving the flash through its strobes and data pins
// Contract
// - load by write pulse, chip select low
// - next load within 30 us
// - page address held on every load
// - chip erase six writes, 80H then 10H
// - sector erase ends with 30H
// - status frozen per read; toggle strobe
// - unlock AAH@5555H, 55H@2AAAH
module flash_host #(
  parameter logic [7:0] READ_STATUS_CODE = 8'h70,
  parameter logic [7:0] CLEAR_STATUS_CODE = 8'h50,
  parameter logic [7:0] SUSPEND_CODE = 8'hB0,
  parameter logic [7:0] RESUME_CODE = 8'hD0,
  parameter int LOAD_CLOSE_CYCLES = flash_host_pkg::LOAD_CLOSE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic [20:0] CMD_ADDR,
  input wire logic WORD_MODE,
  input wire logic LOAD_VALID,
  input wire logic [5:0] LOAD_INDEX,
  input wire logic [15:0] LOAD_DATA,
  input wire logic LOAD_LAST,
  output logic CMD_READY,
  output logic DONE,
  output logic [7:0] STATUS,
  output logic STATUS_FAIL,
  output logic [19:0] FL_ADDR,
  output logic FL_LOW_BYTE_ADDR,
  output logic FL_CS_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  output logic FL_WIDTH_WORD,
  output logic FL_DEEP_SLEEP_N,
  output logic [15:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic [15:0] FL_DQ_I
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_SEQ = 4'h1, ST_SETUP = 4'h2, ST_PULSE = 4'h3,
    ST_HOLD = 4'h4, ST_LOAD = 4'h5, ST_WAITPROG = 4'h6, ST_RD_SETUP = 4'h7,
    ST_RD_PULSE = 4'h8, ST_DONE = 4'h9
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // data pin synchroniser; status is stable while the read strobe is low
  logic [15:0] dq_meta_reg, dq_sync_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_meta_reg <= 16'h0000;
      dq_sync_reg <= 16'h0000;
    end else begin
      dq_meta_reg <= FL_DQ_I;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequence table: index into up to six writes
  function automatic logic [22:0] seq_word(input logic [2:0] op, input logic [2:0] idx,
                                           input logic [20:0] a);
    logic [14:0] u1;
    logic [14:0] u2;
    u1 = flash_host_pkg::UNLOCK_ADDR1;
    u2 = flash_host_pkg::UNLOCK_ADDR2;
    seq_word = {u1, flash_host_pkg::UNLOCK_DATA1};
    if (idx == 3'h1 || idx == 3'h4) seq_word = {u2, flash_host_pkg::UNLOCK_DATA2};
    if (idx == 3'h2) begin
      case (op)
        flash_host_pkg::OP_PROGRAM: seq_word = {u1, flash_host_pkg::CMD_PROGRAM};
        flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE:
          seq_word = {u1, flash_host_pkg::CMD_ERASE_SETUP};
        default: seq_word = {u1, 8'h00};
      endcase
    end
    if (idx == 3'h5) begin
      if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
        seq_word = {a[14:0], flash_host_pkg::CMD_SECTOR_ERASE};
      end else begin
        seq_word = {u1, flash_host_pkg::CMD_CHIP_ERASE};
      end
    end
  endfunction : seq_word

  function automatic logic [7:0] single_code(input logic [2:0] op);
    case (op)
      flash_host_pkg::OP_SUSPEND: single_code = SUSPEND_CODE;
      flash_host_pkg::OP_RESUME: single_code = RESUME_CODE;
      flash_host_pkg::OP_READ_STATUS: single_code = READ_STATUS_CODE;
      flash_host_pkg::OP_CLEAR_STATUS: single_code = CLEAR_STATUS_CODE;
      default: single_code = flash_host_pkg::CMD_READ_ARRAY;
    endcase
  endfunction : single_code

  ////////////////////////////////////////////////////////////////////////////
  state_t state_reg;
  logic [2:0] op_reg;
  logic [2:0] idx_reg;
  logic [20:0] addr_reg;
  logic [15:0] cnt_reg;
  logic [5:0] rd_idx_reg;
  logic [63:0] loaded_reg;
  logic is_load_reg;
  logic suspended_reg;
  logic fail_seen_reg;
  logic [15:0] buf_rd;
  logic [5:0] next_idx;

  wire is_single = (CMD_OP == flash_host_pkg::OP_SUSPEND) ||
                   (CMD_OP == flash_host_pkg::OP_RESUME) ||
                   (CMD_OP == flash_host_pkg::OP_READ_STATUS) ||
                   (CMD_OP == flash_host_pkg::OP_CLEAR_STATUS) ||
                   (CMD_OP == flash_host_pkg::OP_READ_ARRAY);
  wire is_prog_erase = (CMD_OP == flash_host_pkg::OP_PROGRAM) ||
                       (CMD_OP == flash_host_pkg::OP_CHIP_ERASE) ||
                       (CMD_OP == flash_host_pkg::OP_SECTOR_ERASE);
  // a device with a fail bit set refuses work, so don't send it
  wire refuse = is_prog_erase && fail_seen_reg;
  wire cmd_ok = CMD_VALID && CMD_READY && !refuse;
  wire [2:0] seq_len = (op_reg == flash_host_pkg::OP_PROGRAM) ? 3'h3 : 3'h6;
  wire [22:0] seq_now = seq_word(op_reg, idx_reg, addr_reg);
  wire status_done = dq_sync_reg[flash_host_pkg::READY_BIT];
  wire [7:0] status_byte = {dq_sync_reg[7:2], 2'b00};
  wire is_erase_op = (op_reg == flash_host_pkg::OP_CHIP_ERASE) ||
                     (op_reg == flash_host_pkg::OP_SECTOR_ERASE);

  page_buffer u_buf (
    .clk(SYS_CLK),
    .wr_en(LOAD_VALID && state_reg == ST_LOAD),
    .wr_addr(LOAD_INDEX),
    .wr_data(LOAD_DATA),
    .rd_addr(next_idx),
    .rd_data(buf_rd)
  );
  // only indices the user loaded go to the device; the rest stay erased
  assign next_idx = rd_idx_reg;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      op_reg <= 3'h0;
      idx_reg <= 3'h0;
      addr_reg <= 21'h000000;
      cnt_reg <= 16'h0000;
      rd_idx_reg <= 6'h00;
      loaded_reg <= 64'h0;
      is_load_reg <= 1'b0;
      suspended_reg <= 1'b0;
      fail_seen_reg <= 1'b0;
      CMD_READY <= 1'b0;
      DONE <= 1'b0;
      STATUS <= 8'h00;
      STATUS_FAIL <= 1'b0;
      FL_ADDR <= 20'h00000;
      FL_LOW_BYTE_ADDR <= 1'b0;
      FL_CS_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WIDTH_WORD <= 1'b0;
      FL_DEEP_SLEEP_N <= 1'b1;
      FL_DQ_O <= 16'h0000;
      FL_DQ_OE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          CMD_READY <= 1'b1;
          if (cmd_ok) begin
            CMD_READY <= 1'b0;
            op_reg <= CMD_OP;
            addr_reg <= CMD_ADDR;
            idx_reg <= 3'h0;
            loaded_reg <= 64'h0;
            if (CMD_OP == flash_host_pkg::OP_SUSPEND) suspended_reg <= 1'b1;
            if (CMD_OP == flash_host_pkg::OP_RESUME) suspended_reg <= 1'b0;
            if (CMD_OP == flash_host_pkg::OP_CLEAR_STATUS) fail_seen_reg <= 1'b0;
            is_load_reg <= 1'b0;
            if (is_single) begin
              FL_ADDR <= {5'h00, flash_host_pkg::UNLOCK_ADDR1};
              FL_DQ_O <= {8'h00, single_code(CMD_OP)};
              idx_reg <= 3'h5;
            end
            state_reg <= is_single ? ST_SETUP : ST_SEQ;
          end else if (CMD_VALID && CMD_READY && refuse) begin
            DONE <= 1'b1;
          end
        end
        ST_SEQ: begin
          FL_ADDR <= {5'h00, seq_now[22:8]};
          if (op_reg == flash_host_pkg::OP_SECTOR_ERASE && idx_reg == 3'h5)
            FL_ADDR <= {addr_reg[20:16], seq_now[22:8]};
          FL_DQ_O <= {8'h00, seq_now[7:0]};
          // width strap is presented before the third write falls
          if (idx_reg == 3'h2) FL_WIDTH_WORD <= WORD_MODE;
          state_reg <= ST_SETUP;
        end
        ST_SETUP: begin
          FL_CS_N <= 1'b0;
          FL_OE_N <= 1'b1;
          FL_DQ_OE <= 1'b1;
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(flash_host_pkg::SETUP_CYC - 1)) begin
            cnt_reg <= 16'h0000;
            FL_WE_N <= 1'b0;
            state_reg <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(flash_host_pkg::PULSE_CYC - 1)) begin
            cnt_reg <= 16'h0000;
            FL_WE_N <= 1'b1;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(flash_host_pkg::HOLD_CYC - 1)) begin
            cnt_reg <= 16'h0000;
            FL_CS_N <= 1'b1;
            FL_DQ_OE <= 1'b0;
            if (is_load_reg) begin
              state_reg <= ST_LOAD;
            end else if (op_reg == flash_host_pkg::OP_PROGRAM && loaded_reg != 64'h0) begin
              // last load written: the device now times out the load period
              state_reg <= ST_WAITPROG;
            end else if (idx_reg + 3'h1 < seq_len) begin
              idx_reg <= idx_reg + 3'h1;
              state_reg <= ST_SEQ;
            end else if (op_reg == flash_host_pkg::OP_PROGRAM) begin
              is_load_reg <= 1'b1;
              state_reg <= ST_LOAD;
            end else if (is_prog_erase_reg(op_reg) ||
                         op_reg == flash_host_pkg::OP_READ_STATUS) begin
              state_reg <= ST_RD_SETUP;
            end else begin
              state_reg <= ST_DONE;
            end
          end
        end
        ST_LOAD: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (LOAD_VALID) begin
            // word index on A0..A5; byte index adds the low address pin
            FL_ADDR <= {addr_reg[20:7], (FL_WIDTH_WORD ? LOAD_INDEX : {1'b0, LOAD_INDEX[5:1]})};
            FL_LOW_BYTE_ADDR <= FL_WIDTH_WORD ? 1'b0 : LOAD_INDEX[0];
            FL_DQ_O <= LOAD_DATA;
            cnt_reg <= 16'h0000;
            loaded_reg[LOAD_INDEX] <= 1'b1;
            rd_idx_reg <= LOAD_INDEX;
            if (LOAD_LAST) is_load_reg <= 1'b0;
            state_reg <= ST_SETUP;
          end else if (!is_load_reg) begin
            state_reg <= ST_WAITPROG;
          end else if (cnt_reg == 16'(flash_host_pkg::LOAD_GAP_CYC - 1)) begin
            // stop at the 30 us gap limit itself rather than risk a split page
            is_load_reg <= 1'b0;
            state_reg <= ST_WAITPROG;
          end
        end
        ST_WAITPROG: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(LOAD_CLOSE_CYCLES)) begin
            cnt_reg <= 16'h0000;
            state_reg <= ST_RD_SETUP;
          end
        end
        ST_RD_SETUP: begin
          FL_CS_N <= 1'b0;
          FL_OE_N <= 1'b0;
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(flash_host_pkg::PULSE_CYC + 1)) begin
            cnt_reg <= 16'h0000;
            state_reg <= ST_RD_PULSE;
          end
        end
        ST_RD_PULSE: begin
          FL_OE_N <= 1'b1;
          FL_CS_N <= 1'b1;
          STATUS <= status_byte;
          if (status_done) begin
            if (dq_sync_reg[flash_host_pkg::ERASE_FAIL_BIT] ||
                dq_sync_reg[flash_host_pkg::PROGRAM_FAIL_BIT]) begin
              fail_seen_reg <= 1'b1;
            end
            state_reg <= ST_DONE;
          end else begin
            state_reg <= ST_RD_SETUP;
          end
        end
        ST_DONE: begin
          DONE <= 1'b1;
          STATUS_FAIL <= fail_seen_reg;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (suspended_reg && is_erase_op && op_reg == flash_host_pkg::OP_CHIP_ERASE)
        suspended_reg <= 1'b0;
    end
  end

  function automatic logic is_prog_erase_reg(input logic [2:0] op);
    is_prog_erase_reg = (op == flash_host_pkg::OP_CHIP_ERASE) ||
                        (op == flash_host_pkg::OP_SECTOR_ERASE);
  endfunction : is_prog_erase_reg

  ////////////////////////////////////////////////////////////////////////////
  a_write_low_cs: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !FL_WE_N |-> !FL_CS_N && FL_OE_N) else $error("write strobe without select");
  a_write_width: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(FL_WE_N) |=> !FL_WE_N [*2]) else $error("write pulse too short");
  a_no_bus_fight: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    FL_DQ_OE |-> FL_OE_N) else $error("driving data during read");
  a_refuse_fail: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_IDLE && CMD_VALID && is_prog_erase && fail_seen_reg |=> state_reg == ST_IDLE)
    else $error("work started while fail set");
  a_read_toggle: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    state_reg == ST_RD_PULSE |=> FL_OE_N) else $error("status read not toggled");
  a_load_addr: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(FL_WE_N) && state_reg == ST_PULSE && op_reg == flash_host_pkg::OP_PROGRAM &&
    idx_reg == 3'h2 && loaded_reg != 64'h0 |-> FL_ADDR[19:6] == addr_reg[20:7])
    else $error("page address lost");
  a_sleep_high: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    FL_DEEP_SLEEP_N) else $error("deep sleep driven");
  a_done_pulse: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    DONE |=> !DONE || state_reg == ST_IDLE) else $error("done stuck");
endmodule : flash_host

// ### flash_dev_model.sv
`timescale 1ns/1ps
// pin-level behavioural model of the parallel flash device
module flash_dev_model #(
  parameter logic [7:0] READ_STATUS_CODE = 8'h70,
  parameter logic [7:0] CLEAR_STATUS_CODE = 8'h50,
  parameter logic [7:0] SUSPEND_CODE = 8'hB0,
  parameter logic [7:0] RESUME_CODE = 8'hD0,
  parameter int CLOSE_NS = 500,
  parameter int BUSY_TICKS = 40
) (
  input wire logic [19:0] addr,
  input wire logic low_byte_addr,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic width_word,
  input wire logic deep_sleep_n,
  input wire logic fail_next,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o
);
  logic [7:0] mem [int];
  logic [7:0] pg [int];
  logic [20:0] ba;
  logic [14:0] ca;
  logic [13:0] page;
  logic [3:0] sector;
  logic mode = 1'b0;
  logic loading = 1'b0;
  logic width_q = 1'b0;
  logic page_err = 1'b0;
  logic rdy = 1'b1;
  logic sus = 1'b0;
  logic efail = 1'b0;
  logic pfail = 1'b0;
  int step = 0;
  int op = 0;
  int busy_left = 0;
  int wr_count = 0;
  realtime last_rise = 0;
  // a write needs both strobes low with the output strobe high
  wire wr_n = we_n | cs_n | ~oe_n;
  wire rd_n = oe_n | cs_n;
  wire [20:0] ra = width_q ? {addr, 1'b0} : {addr, low_byte_addr};
  wire [7:0] sr = {rdy, sus, efail, pfail, 4'h0};
  initial dq_o = 16'h0000;

  function automatic logic [7:0] rdb(input int k);
    return mem.exists(k) ? mem[k] : 8'hFF;
  endfunction : rdb

  task automatic start(input int kind);
    mode = 1'b1;
    if (efail || pfail) return;
    op = kind;
    rdy = 1'b0;
    loading = (kind == 0);
    last_rise = $realtime;
    sector = ba[20:17];
    if (kind != 0) busy_left = BUSY_TICKS;
  endtask : start

  task automatic finish_op;
    int q[$];
    rdy = 1'b1;
    if (fail_next && op == 0) pfail = 1'b1;
    else if (fail_next) efail = 1'b1;
    else if (op == 0) foreach (pg[k]) mem[k] = pg[k];
    else foreach (mem[k]) if (op == 1 || k[20:17] == sector) q.push_back(k);
    foreach (q[i]) mem.delete(q[i]);
    pg.delete();
  endtask : finish_op

  ////////////////////////////////////////////////////////////////
  always @(negedge wr_n) begin
    if (step == 2 && !loading) width_q = width_word;
    ba = width_q ? {addr, 1'b0} : {addr, low_byte_addr};
    ca = addr[14:0];
    wr_count++;
    if (loading && pg.num() == 0) page = ba[20:7];
    if (loading && ba[20:7] != page) page_err = 1'b1;
  end

  always @(posedge wr_n) begin
    logic [7:0] d;
    int s;
    d = dq_i[7:0];
    s = step;
    step = 0;
    if (loading) begin
      pg[ba] = d;
      if (width_q) pg[ba + 1] = dq_i[15:8];
      last_rise = $realtime;
    end else if (d == READ_STATUS_CODE) mode = 1'b1;
    else if (d == flash_host_pkg::CMD_READ_ARRAY) mode = (busy_left != 0 && !sus);
    else if (d == RESUME_CODE && sus) begin
      sus = 1'b0;
      rdy = 1'b0;
    end else if (d == SUSPEND_CODE) begin
      mode = 1'b1;
      sus = (busy_left > 0 && op == 2);
      rdy = rdy | sus;
    end else if (sus) step = 0;
    else if (d == CLEAR_STATUS_CODE) {efail, pfail} = 2'b00;
    else if ((s == 0 || s == 3) && d == 8'hAA && ca == 15'h5555) step = s + 1;
    else if ((s == 1 || s == 4) && d == 8'h55 && ca == 15'h2AAA) step = s + 1;
    else if (s == 2 && d == flash_host_pkg::CMD_ERASE_SETUP) step = 3;
    else if (s == 2 && d == flash_host_pkg::CMD_PROGRAM) start(0);
    else if (s == 5 && d == flash_host_pkg::CMD_CHIP_ERASE) start(1);
    else if (s == 5 && d == flash_host_pkg::CMD_SECTOR_ERASE) start(2);
  end

  // the engine advances on its own time base, frozen while suspended
  always #25 begin
    if (loading && $realtime - last_rise >= CLOSE_NS) begin
      loading = 1'b0;
      busy_left = BUSY_TICKS;
    end else if (busy_left > 0 && !sus) begin
      busy_left--;
      if (busy_left == 0) finish_op();
    end
  end

  always @(negedge deep_sleep_n) begin
    {mode, loading, sus, efail, pfail, rdy} = 6'h01;
    busy_left = 0;
  end

  // status is frozen per read; a released bus shows the inverse
  always @(negedge rd_n) begin
    if (mode) dq_o = {width_q ? 8'h00 : ~dq_o[15:8], sr};
    else dq_o = {rdb(ra + 1), rdb(ra)};
  end
  always @(posedge rd_n) dq_o = ~dq_o;
endmodule : flash_dev_model

// ### flash_host_tb.sv
`timescale 1ns/1ps
// self-checking bench for flash_host against the flash pin model
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module flash_host_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic word_mode = 1'b1;
  logic load_valid = 1'b0;
  logic load_last = 1'b0;
  logic fail_next = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [20:0] cmd_addr = 21'h000000;
  logic [5:0] load_index = 6'h00;
  logic [15:0] load_data = 16'h0000;
  logic cmd_ready, done, status_fail, lba, cs_n, we_n, oe_n, width, sleep_n, dq_oe;
  logic [7:0] status;
  logic [19:0] fl_addr;
  logic [15:0] dq_o, dev_dq;
  wire [15:0] dq_bus = dq_oe ? dq_o : dev_dq;
  int num_checks = 0;
  int miscompares = 0;
  always #12.5 sys_clk = ~sys_clk;

  flash_host #(.LOAD_CLOSE_CYCLES(20)) DUT (.SYS_CLK(sys_clk), .RSTN(rstn),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .WORD_MODE(word_mode),
    .LOAD_VALID(load_valid), .LOAD_INDEX(load_index), .LOAD_DATA(load_data),
    .LOAD_LAST(load_last), .CMD_READY(cmd_ready), .DONE(done), .STATUS(status),
    .STATUS_FAIL(status_fail), .FL_ADDR(fl_addr), .FL_LOW_BYTE_ADDR(lba), .FL_CS_N(cs_n),
    .FL_WE_N(we_n), .FL_OE_N(oe_n), .FL_WIDTH_WORD(width), .FL_DEEP_SLEEP_N(sleep_n),
    .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_bus));
  flash_dev_model dev (.addr(fl_addr), .low_byte_addr(lba), .cs_n(cs_n), .we_n(we_n),
    .oe_n(oe_n), .width_word(width), .deep_sleep_n(sleep_n), .fail_next(fail_next),
    .dq_i(dq_bus), .dq_o(dev_dq));

  ////////////////////////////////////////////////////////////////
  task automatic send(input logic [2:0] op, input logic [20:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    do @(posedge sys_clk);
    while (cmd_ready !== 1'b1 && ++n < 1000);
    `CHK("cmd ready", 1'b1, cmd_ready)
    cmd_valid <= 1'b0;
  endtask : send

  task automatic run(input logic [2:0] op, input logic [20:0] a);
    int n;
    n = 0;
    send(op, a);
    while (done !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("done", 1'b1, done)
  endtask : run

  // the design gives no load acknowledge, so the model's write count serves
  task automatic load(input logic [5:0] i, input logic [15:0] d, input logic last);
    int c, n;
    c = dev.wr_count;
    n = 0;
    @(posedge sys_clk);
    load_index <= i;
    load_data <= d;
    load_last <= last;
    load_valid <= 1'b1;
    while (dev.wr_count == c && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    load_valid <= 1'b0;
    load_last <= 1'b0;
  endtask : load

  task automatic open_page(input logic wm, input logic [20:0] a);
    int n;
    n = 0;
    word_mode <= wm;
    send(flash_host_pkg::OP_PROGRAM, a);
    while (dev.loading !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : open_page

  function automatic logic [15:0] rd16(input int k);
    return {dev.rdb(k + 1), dev.rdb(k)};
  endfunction : rd16

  ////////////////////////////////////////////////////////////////
  task automatic t_word_program;
    open_page(1'b1, 21'h0A0080);
    load(6'h05, 16'h1234, 1'b0);
    load(6'h00, 16'hBEEF, 1'b0);
    load(6'h3F, 16'hCAFE, 1'b1);
    run(flash_host_pkg::OP_READ_STATUS, 21'h0);
    `CHK("width", 1'b1, dev.width_q)
    `CHK("word5", 16'h1234, rd16(21'h0A008A))
    `CHK("word0", 16'hBEEF, rd16(21'h0A0080))
    `CHK("word63", 16'hCAFE, rd16(21'h0A00FE))
    `CHK("unloaded", 16'hFFFF, rd16(21'h0A0082))
    `CHK("page", 1'b0, dev.page_err)
    `CHK("ready", 1'b1, status[7])
    `CHK("low bits", 4'h0, status[3:0])
  endtask : t_word_program

  task automatic t_byte_program;
    open_page(1'b0, 21'h1C0000);
    load(6'h07, 16'h00A5, 1'b0);
    load(6'h06, 16'h005A, 1'b1);
    run(flash_host_pkg::OP_READ_STATUS, 21'h0);
    `CHK("width", 1'b0, dev.width_q)
    `CHK("byte7", 8'hA5, dev.rdb(21'h1C0007))
    `CHK("byte6", 8'h5A, dev.rdb(21'h1C0006))
    `CHK("byte8", 8'hFF, dev.rdb(21'h1C0008))
  endtask : t_byte_program

  task automatic t_erase;
    run(flash_host_pkg::OP_SECTOR_ERASE, 21'h1C0000);
    `CHK("sector", 4'hE, dev.sector)
    `CHK("erased", 8'hFF, dev.rdb(21'h1C0007))
    `CHK("kept", 16'h1234, rd16(21'h0A008A))
    `CHK("ready", 1'b1, status[7])
    run(flash_host_pkg::OP_CHIP_ERASE, 21'h0);
    `CHK("chip", 16'hFFFF, rd16(21'h0A008A))
    `CHK("mode", 1'b1, dev.mode)
  endtask : t_erase

  task automatic t_suspend_idle;
    run(flash_host_pkg::OP_SUSPEND, 21'h0);
    run(flash_host_pkg::OP_READ_STATUS, 21'h0);
    `CHK("no suspend", 1'b0, status[6])
    run(flash_host_pkg::OP_RESUME, 21'h0);
    `CHK("resume", 1'b0, dev.sus)
    run(flash_host_pkg::OP_READ_ARRAY, 21'h0);
    `CHK("array", 1'b0, dev.mode)
  endtask : t_suspend_idle

  task automatic t_fail;
    int c;
    fail_next <= 1'b1;
    open_page(1'b1, 21'h000100);
    load(6'h01, 16'h0F0F, 1'b1);
    run(flash_host_pkg::OP_READ_STATUS, 21'h0);
    fail_next <= 1'b0;
    `CHK("prog fail", 1'b1, status[4])
    `CHK("fail flag", 1'b1, status_fail)
    c = dev.wr_count;
    run(flash_host_pkg::OP_CHIP_ERASE, 21'h0);
    `CHK("refused", c, dev.wr_count)
    run(flash_host_pkg::OP_CLEAR_STATUS, 21'h0);
    run(flash_host_pkg::OP_READ_STATUS, 21'h0);
    `CHK("cleared", 2'b00, status[5:4])
    `CHK("flag clear", 1'b0, status_fail)
  endtask : t_fail

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("idle strobes", 3'b111, {cs_n, we_n, oe_n})
    `CHK("sleep pin", 1'b1, sleep_n)
    `CHK("power-up mode", 1'b0, dev.mode)
    t_word_program();
    t_byte_program();
    t_erase();
    t_suspend_idle();
    t_fail();
    conclude();
  end
endmodule : flash_host_tb
